/* pkg/pcdmux_pkg.sv */
package pcdmux_pkg;
  // ------------------------------------------------------------
  // Pin function codes
  // ------------------------------------------------------------
  localparam logic [1:0] FN_MCU_IO = 2'h0;
  localparam logic [1:0] FN_MACROCELL = 2'h1;
  localparam logic [1:0] FN_LOGIC_IN = 2'h2;
  localparam logic [1:0] FN_DEDICATED = 2'h3;
  // ------------------------------------------------------------
  // Pin positions
  // ------------------------------------------------------------
  localparam int PC_TMS = 0;
  localparam int PC_TCK = 1;
  localparam int PC_STATUS = 3;
  localparam int PC_ERROR = 4;
  localparam int PC_TDI = 5;
  localparam int PC_TDO = 6;
  localparam int PC_BYTE_EN = 7;
  localparam int PD_ALS = 0;
  localparam int PD_LOGIC_CLOCK_IN = 1;
  localparam int PD_CSEL = 2;
  localparam int PC_WIDTH = 8;
  localparam int PD_WIDTH = 3;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PC_OUT = 8'h00;
  localparam logic [2:0] RST_PD_OUT = 3'h0;
  localparam logic RST_CSEL_N = 1'b1;
endpackage

/* hdl/pcdmux_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser bank for pin inputs
module pcdmux_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

/* hdl/pcdmux_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each port C pin picks MCU I/O, macrocell, logic input or dedicated
// - Test port maps bit0 TMS, 1 TCK, 3 status, 4 error, 5 TDI, 6 TDO
// - Test-port signals switch onto port C only when enabled
// - Each port C output is push-pull or open-drain
// - Port C bit 7 can be active-low byte enable input from host
// - Port D bit 0 can be the host address latch strobe input
// - Port D bit 1 can be the logic clock input for macrocells
// - Port D bit 2 chip select: low allows access, high disables memory
// - Port D pins can be MCU I/O, logic inputs, or chip-select outputs
// - Whole device programmable through test port without the host
// - Logic and configuration programmed only via test port, not host
module pcdmux_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Port C pins
  input wire logic [7:0] portc_in,
  output logic [7:0] portc_out,
  output logic [7:0] portc_oe_n,
  // Port D pins
  input wire logic [2:0] portd_in,
  output logic [2:0] portd_out,
  output logic [2:0] portd_oe_n,
  // Per-pin configuration: function two bits per pin, open-drain one bit per port C pin
  input wire logic [15:0] portc_func,
  input wire logic [5:0] portd_func,
  input wire logic [7:0] portc_open_drain,
  input wire logic test_port_en,
  // General purpose port registers
  input wire logic [7:0] portc_data_out,
  input wire logic [7:0] portc_dir,
  input wire logic [2:0] portd_data_out,
  input wire logic [2:0] portd_dir,
  output logic [7:0] portc_data_in,
  output logic [2:0] portd_data_in,
  // Logic array side
  input wire logic [7:0] shared_macrocell_out,
  input wire logic [2:0] ext_chip_sel_out,
  output logic [7:0] portc_logic_in,
  output logic [2:0] portd_logic_in,
  // Test port side
  output logic test_tms,
  output logic test_tck,
  output logic test_tdi,
  input wire logic test_tdo,
  input wire logic prog_status_out,
  input wire logic prog_error_out,
  output logic prog_config_allow,
  // Host bus dedicated inputs
  output logic byte_enable_n,
  output logic address_latch_strobe,
  output logic logic_clock_in,
  output logic chip_sel_n,
  output logic memory_enable,
  output logic host_config_write_allow
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [7:0] pc_sync;
  logic [2:0] pd_sync;

  pcdmux_sync #(.WIDTH(8)) u_sync_c (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(portc_in),
    .sync_out(pc_sync)
  );

  pcdmux_sync #(.WIDTH(3)) u_sync_d (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(portd_in),
    .sync_out(pd_sync)
  );

  // ------------------------------------------------------------
  // Port C selection
  // ------------------------------------------------------------
  // Which pins the test port owns, and which of those it drives
  localparam logic [7:0] TEST_PINS = 8'h7b;
  localparam logic [7:0] TEST_OUTS = 8'h58;
  wire [7:0] test_own = test_port_en ? TEST_PINS : 8'h00;
  wire [7:0] test_val = {1'b0, test_tdo, 1'b0, prog_error_out,
                         prog_status_out, 3'h0};
  logic [7:0] next_pc_out;
  logic [7:0] next_pc_drive;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pc
      wire [1:0] fn = portc_func[2*i+1:2*i];
      wire ded = (fn == pcdmux_pkg::FN_DEDICATED);
      wire ded_drive = (i == pcdmux_pkg::PC_STATUS) ||
                       (i == pcdmux_pkg::PC_ERROR) ||
                       (i == pcdmux_pkg::PC_TDO);
      always_comb begin
        // Test port overrides every other choice on its pins
        if (test_own[i]) begin
          next_pc_out[i] = test_val[i];
          next_pc_drive[i] = TEST_OUTS[i];
        end else if (fn == pcdmux_pkg::FN_MACROCELL) begin
          next_pc_out[i] = shared_macrocell_out[i];
          next_pc_drive[i] = 1'b1;
        end else if (fn == pcdmux_pkg::FN_MCU_IO) begin
          next_pc_out[i] = portc_data_out[i];
          next_pc_drive[i] = portc_dir[i];
        end else begin
          // Logic input, or dedicated input such as byte enable
          next_pc_out[i] = 1'b0;
          next_pc_drive[i] = ded && ded_drive && test_port_en;
        end
      end
      // Open drain only pulls low; a high releases the pin
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          portc_out[i] <= pcdmux_pkg::RST_PC_OUT[i];
          portc_oe_n[i] <= 1'b1;
        end else if (clk_en) begin
          portc_out[i] <= next_pc_out[i];
          portc_oe_n[i] <= !(next_pc_drive[i] &&
                             !(portc_open_drain[i] && next_pc_out[i]));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Port D selection
  // ------------------------------------------------------------
  generate
    for (i = 0; i < 3; i++) begin : g_pd
      wire [1:0] fn = portd_func[2*i+1:2*i];
      wire drv = (fn == pcdmux_pkg::FN_MACROCELL) ||
                 ((fn == pcdmux_pkg::FN_MCU_IO) && portd_dir[i]);
      wire val = (fn == pcdmux_pkg::FN_MACROCELL) ? ext_chip_sel_out[i]
                 : portd_data_out[i];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          portd_out[i] <= pcdmux_pkg::RST_PD_OUT[i];
          portd_oe_n[i] <= 1'b1;
        end else if (clk_en) begin
          portd_out[i] <= drv ? val : 1'b0;
          portd_oe_n[i] <= !drv;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Dedicated inputs and read-back
  // ------------------------------------------------------------
  wire [1:0] fn_be = portc_func[2*pcdmux_pkg::PC_BYTE_EN+1 -: 2];
  wire [1:0] fn_als = portd_func[2*pcdmux_pkg::PD_ALS+1 -: 2];
  wire [1:0] fn_clk = portd_func[2*pcdmux_pkg::PD_LOGIC_CLOCK_IN+1 -: 2];
  wire [1:0] fn_cs = portd_func[2*pcdmux_pkg::PD_CSEL+1 -: 2];
  wire be_sel = (fn_be == pcdmux_pkg::FN_DEDICATED);
  wire als_sel = (fn_als == pcdmux_pkg::FN_DEDICATED);
  wire clk_sel = (fn_clk == pcdmux_pkg::FN_DEDICATED);
  wire cs_sel = (fn_cs == pcdmux_pkg::FN_DEDICATED);
  wire next_cs_n = cs_sel ? pd_sync[pcdmux_pkg::PD_CSEL]
                   : pcdmux_pkg::RST_CSEL_N ^ 1'b1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      byte_enable_n <= 1'b1;
      address_latch_strobe <= 1'b0;
      logic_clock_in <= 1'b0;
      chip_sel_n <= pcdmux_pkg::RST_CSEL_N;
      memory_enable <= 1'b0;
      test_tms <= 1'b0;
      test_tck <= 1'b0;
      test_tdi <= 1'b0;
      portc_data_in <= 8'h00;
      portd_data_in <= 3'h0;
      portc_logic_in <= 8'h00;
      portd_logic_in <= 3'h0;
    end else if (clk_en) begin
      // Idle high when not selected so no byte is qualified by accident
      byte_enable_n <= be_sel ? pc_sync[pcdmux_pkg::PC_BYTE_EN]
                       : 1'b1;
      address_latch_strobe <= als_sel & pd_sync[pcdmux_pkg::PD_ALS];
      // Sampled clock: only suits clock rates well below sys_clk
      logic_clock_in <= clk_sel & pd_sync[pcdmux_pkg::PD_LOGIC_CLOCK_IN];
      chip_sel_n <= next_cs_n;
      memory_enable <= !next_cs_n;
      test_tms <= test_port_en & pc_sync[pcdmux_pkg::PC_TMS];
      test_tck <= test_port_en & pc_sync[pcdmux_pkg::PC_TCK];
      test_tdi <= test_port_en & pc_sync[pcdmux_pkg::PC_TDI];
      portc_data_in <= pc_sync;
      portd_data_in <= pd_sync;
      portc_logic_in <= pc_sync;
      portd_logic_in <= pd_sync;
    end
  end

  // Programming of logic and configuration needs only the test port
  assign prog_config_allow = test_port_en;
  assign host_config_write_allow = 1'b0;
endmodule
`default_nettype wire

/* test/pcdmux_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pcdmux_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] portc_in,
  input wire logic [7:0] portc_out,
  input wire logic [7:0] portc_oe_n,
  input wire logic [2:0] portd_in,
  input wire logic [15:0] portc_func,
  input wire logic [5:0] portd_func,
  input wire logic [7:0] portc_open_drain,
  input wire logic test_port_en,
  input wire logic [7:0] portc_data_out,
  input wire logic [7:0] portc_dir,
  input wire logic [7:0] shared_macrocell_out,
  input wire logic test_tck,
  input wire logic test_tdo,
  input wire logic prog_config_allow,
  input wire logic byte_enable_n,
  input wire logic address_latch_strobe,
  input wire logic chip_sel_n,
  input wire logic memory_enable,
  input wire logic host_config_write_allow
);
  // Pin paths lag three edges, so hold off that long after reset
  logic [2:0] rh;
  always_ff @(posedge sys_clk) rh <= {rh[1:0], rst};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || |rh || !clk_en);
  AST_TCK_OFF: assert property (
    !$past(test_port_en) |-> !test_tck)
    else $error("tck active with test port off");
  AST_TDO: assert property (
    $past(test_port_en && !portc_open_drain[6]) |->
    !portc_oe_n[6] && portc_out[6] == $past(test_tdo)) else $error("tdo pin");
  AST_DRIVE: assert property (
    $past(portc_func[5:4] == 2'h0 && portc_dir[2])
    |-> portc_oe_n[2] == $past(portc_open_drain[2] & portc_data_out[2]))
    else $error("pin 2 drive mode");
  AST_MACRO: assert property ($past(portc_func[5:4] == 2'h1) |->
    portc_out[2] == $past(shared_macrocell_out[2])) else $error("macrocell");
  AST_BYTE_EN: assert property (
    $past(portc_func[15:14] == 2'h3) |->
    byte_enable_n == $past(portc_in[7], 3)) else $error("byte enable");
  AST_CSEL: assert property ($past(portd_func[5:4] == 2'h3) |->
    chip_sel_n == $past(portd_in[2], 3) && memory_enable != chip_sel_n)
    else $error("chip select");
  AST_STROBE: assert property ($past(portd_func[1:0] == 2'h3) |->
    address_latch_strobe == $past(portd_in[0], 3)) else $error("strobe");
  AST_CONFIG: assert property (!host_config_write_allow &&
    prog_config_allow == test_port_en) else $error("config path");
endmodule
`default_nettype wire

/* test/pcdmux_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pcdmux_host (
  input wire logic [7:0] portc_out,
  input wire logic [7:0] portc_oe_n,
  input wire logic [2:0] portd_out,
  input wire logic [2:0] portd_oe_n,
  input wire logic [7:0] host_c,
  input wire logic [2:0] host_d,
  output logic [7:0] portc_in,
  output logic [2:0] portd_in
);
  // Host and programmer drive a pin only where the block lets go
  assign portc_in = (portc_out & ~portc_oe_n) |
    (host_c & portc_oe_n);
  assign portd_in = (portd_out & ~portd_oe_n) |
    (host_d & portd_oe_n);
endmodule
`default_nettype wire

/* test/pcdmux_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pcdmux_top_tb;
  logic sys_clk = 0, rst = 1, clk_en = 1, test_port_en = 0, test_tdo = 0;
  logic prog_status_out = 0, prog_error_out = 0;
  logic [15:0] portc_func = 16'h0;
  logic [5:0] portd_func = 6'h0;
  logic [7:0] portc_open_drain = 8'h0, portc_data_out = 8'h0;
  logic [7:0] portc_dir = 8'h0, shared_macrocell_out = 8'h0, host_c = 8'hff;
  logic [2:0] portd_data_out = 3'h0, portd_dir = 3'h0;
  logic [2:0] ext_chip_sel_out = 3'h0, host_d = 3'h7;
  logic [7:0] portc_in, portc_out, portc_oe_n, portc_data_in, portc_logic_in;
  logic [2:0] portd_in, portd_out, portd_oe_n, portd_data_in, portd_logic_in;
  logic test_tms, test_tck, test_tdi, prog_config_allow, byte_enable_n;
  logic address_latch_strobe, logic_clock_in, chip_sel_n, memory_enable;
  logic host_config_write_allow;
  int miscompares = 0;
  int compares = 0;
  pcdmux_top dut_u (.*);
  pcdmux_host host_u (.*);
  always #20 sys_clk = ~sys_clk;
  task w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_jtag;
    {test_port_en, test_tdo, prog_status_out} = 3'h7;
    host_c = 8'h23;
    w(4);
    chk("tms", 8'h1, test_tms);
    chk("tck", 8'h1, test_tck);
    chk("tdi", 8'h1, test_tdi);
    chk("tp out", 8'h48, portc_out & ~portc_oe_n & 8'h58);
    chk("allow", 8'h1, prog_config_allow);
    test_port_en = 1'b0;
    w(4);
    chk("tck off", 8'h0, test_tck);
    chk("din", 8'h23, portc_data_in & 8'h23);
  endtask
  task t_gpio;
    {portc_dir, portc_data_out} = {8'h04, 8'h04};
    w(2);
    chk("push", 8'h04, portc_out & ~portc_oe_n & 8'h04);
    portc_open_drain = 8'h04;
    w(2);
    chk("od rel", 8'h04, portc_oe_n & 8'h04);
    portc_data_out = 8'h00;
    w(2);
    chk("od low", 8'h00, (portc_out | portc_oe_n) & 8'h04);
  endtask
  task t_macro;
    {portc_open_drain, portc_dir, shared_macrocell_out} = {16'h0, 8'h04};
    portc_func = 16'h0010;
    w(2);
    chk("mcell", 8'h04, portc_out & ~portc_oe_n & 8'h04);
    {portc_func, host_c} = {16'h0020, 8'h27};
    w(4);
    chk("lin", 8'h04, portc_logic_in & 8'h04);
  endtask
  task t_host;
    {portc_func, portd_func} = {16'hc000, 6'h3f};
    for (int i = 0; i < 8; i++) begin
      host_d = i[2:0];
      host_c[7] = i[0];
      w(4);
      chk("strobe", {7'h0, i[0]}, address_latch_strobe);
      chk("logic_clock_in", {7'h0, i[1]}, logic_clock_in);
      chk("csel", {7'h0, i[2]}, chip_sel_n);
      chk("mem", {7'h0, ~i[2]}, memory_enable);
      chk("be", {7'h0, i[0]}, byte_enable_n);
      chk("pd din", {5'h0, i[2:0]}, {5'h0, portd_data_in});
      chk("pd lin", {5'h0, i[2:0]}, {5'h0, portd_logic_in});
    end
    {portd_func, ext_chip_sel_out} = {6'h04, 3'h2};
    w(2);
    chk("pd out", 8'h2, {5'h0, portd_out & ~portd_oe_n});
  endtask
  initial begin
    w(5);
    rst = 1'b0;
    chk("oe rst", 8'hff, portc_oe_n);
    t_jtag();
    t_gpio();
    t_macro();
    t_host();
    test_done();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
endmodule
bind pcdmux_top pcdmux_props props_u (.*);
`default_nettype wire
